// ===== bench/perf_state_properties.sv
`timescale 1ns/1ps
module perf_state_properties (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic REG_RD_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic THERMAL_HEADROOM_I,
  input wire logic BOOST_CRITERIA_I,
  input wire logic [63:0] REG_RDATA_O,
  input wire logic [31:0] ID_FEATURE_ECX_O,
  input wire logic [31:0] ID_POWER_LEAF_ECX_O,
  input wire logic [15:0] OPERATING_POINT_O,
  input wire logic TRANSITION_BUSY_O,
  input wire logic BOOST_ENGAGED_O
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  sequence rd_status;
    REG_RD_I && REG_ADDR_I == perf_state_pkg::ADDR_PERF_CURRENT_STATUS;
  endsequence
  sequence step_run;
    TRANSITION_BUSY_O [*8];
  endsequence
  sequence step_tail;
    TRANSITION_BUSY_O [*4] ##1 !TRANSITION_BUSY_O;
  endsequence
  chk_id_transition: assert property (ID_FEATURE_ECX_O[7]) else $error("feature bit low");
  chk_id_counters: assert property (ID_POWER_LEAF_ECX_O[0]) else $error("leaf bit low");
  chk_status_private: assert property (rd_status |=> !REG_RDATA_O[32]) else $error("bit 32 seen");
  chk_status_point: assert property (rd_status |=> REG_RDATA_O[15:0] == $past(OPERATING_POINT_O))
    else $error("status differs from point");
  chk_step_hold: assert property ($rose(TRANSITION_BUSY_O) |-> step_run) else $error("step too short");
  chk_step_length: assert property ($rose(TRANSITION_BUSY_O) |-> step_run ##1 step_run ##1 step_tail)
    else $error("step length wrong");
  chk_point_stride: assert property ($changed(OPERATING_POINT_O) |->
    (OPERATING_POINT_O - $past(OPERATING_POINT_O) == 16'h0001) ||
    ($past(OPERATING_POINT_O) - OPERATING_POINT_O == 16'h0001)) else $error("point jumped");
  chk_boost_cause: assert property (BOOST_ENGAGED_O |-> $past(THERMAL_HEADROOM_I && BOOST_CRITERIA_I))
    else $error("boost without cause");
  chk_boost_drop: assert property (!THERMAL_HEADROOM_I |=> !BOOST_ENGAGED_O) else $error("boost kept");
  chk_rdata_hold: assert property (!$past(REG_RD_I) |-> $stable(REG_RDATA_O)) else $error("rdata moved");
endmodule
bind perf_state_ctrl_feedback perf_state_properties i_perf_state_properties (.CLK_SYS_I, .RST_I, .REG_RD_I,
  .REG_ADDR_I, .THERMAL_HEADROOM_I, .BOOST_CRITERIA_I, .REG_RDATA_O, .ID_FEATURE_ECX_O, .ID_POWER_LEAF_ECX_O,
  .OPERATING_POINT_O, .TRANSITION_BUSY_O, .BOOST_ENGAGED_O);

// ===== bench/tb_perf_state_ctrl_feedback.sv
`timescale 1ns/1ps
module tb_perf_state_ctrl_feedback;
  localparam logic [11:0] MISC_A = perf_state_pkg::ADDR_MISC_FEATURE_ENABLE;
  localparam logic [11:0] STS_A = perf_state_pkg::ADDR_PERF_CURRENT_STATUS;
  localparam logic [11:0] CTL_A = perf_state_pkg::ADDR_PERF_TARGET_CONTROL;
  localparam logic [11:0] REF_A = perf_state_pkg::ADDR_REFERENCE_CYCLE_COUNT;
  localparam logic [11:0] ACT_A = perf_state_pkg::ADDR_ACTUAL_CYCLE_COUNT;
  typedef struct {logic [11:0] a; logic [63:0] e;} row_s;
  row_s rows [6] = '{'{MISC_A, 64'h0}, '{STS_A, 64'h0}, '{CTL_A, 64'h0}, '{REF_A, 64'h0}, '{ACT_A, 64'h0},
    '{12'h100, 64'h0}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [63:0] wdata = 64'h0;
  logic active = 1'b0;
  logic tick = 1'b0;
  logic headroom = 1'b0;
  logic criteria = 1'b0;
  logic [63:0] rdata;
  logic [15:0] point;
  logic busy;
  logic boost;
  logic [63:0] v;
  logic [63:0] w;
  int failures = 0;
  int compares = 0;
  perf_state_ctrl_feedback i_perf_state_ctrl_feedback (.CLK_SYS_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .ACTIVE_STATE_I(active), .CORE_CLK_TICK_I(tick),
    .THERMAL_HEADROOM_I(headroom), .BOOST_CRITERIA_I(criteria), .REG_RDATA_O(rdata), .ID_FEATURE_ECX_O(),
    .ID_POWER_LEAF_ECX_O(), .OPERATING_POINT_O(point), .TRANSITION_BUSY_O(busy), .BOOST_ENGAGED_O(boost));
  always #25 clk = ~clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [11:0] a, input logic [63:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data lands on the read edge, so sample at the following falling edge
  task automatic get(input logic [11:0] a, output logic [63:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic conclude;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #(50 * 6000);
    failures++;
    conclude();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      get(rows[i].a, v);
      check(v, rows[i].e);
    end
    put(CTL_A, 64'h5);
    get(CTL_A, v);
    check(v, 64'h0);
    check({48'h0, point}, 64'h0);
    put(MISC_A, 64'h1_0000);
    get(MISC_A, v);
    check(v, 64'h1_0000);
    @(posedge clk);
    headroom <= 1'b1;
    criteria <= 1'b1;
    put(CTL_A, 64'h1_0000_0002);
    put(CTL_A, 64'h1_0000_0003);
    get(CTL_A, v);
    check(v, 64'h1_0000_0003);
    check({63'h0, busy}, 64'h1);
    for (int n = 0; n < 200 && point !== 16'h3; n++) @(negedge clk);
    get(STS_A, v);
    check(v, 64'h3);
    check({63'h0, busy}, 64'h0);
    check({63'h0, boost}, 64'h0);
    put(CTL_A, 64'h3);
    repeat (3) @(negedge clk);
    check({63'h0, boost}, 64'h1);
    @(posedge clk);
    headroom <= 1'b0;
    repeat (3) @(negedge clk);
    check({63'h0, boost}, 64'h0);
    put(REF_A, 64'hFFFF_FFFF_FFFF_FFFF);
    put(ACT_A, 64'h100);
    get(REF_A, v);
    check(v, 64'hFFFF_FFFF_FFFF_FFFF);
    get(ACT_A, v);
    check(v, 64'h100);
    @(posedge clk);
    active <= 1'b1;
    tick <= 1'b1;
    repeat (6) @(posedge clk);
    active <= 1'b0;
    tick <= 1'b0;
    get(ACT_A, v);
    check({63'h0, v < 64'h6}, 64'h1);
    get(REF_A, v);
    check({63'h0, v < 64'h2}, 64'h1);
    repeat (20) @(posedge clk);
    get(REF_A, w);
    check(w, v);
    put(REF_A, 64'h0);
    put(ACT_A, 64'h0);
    @(posedge clk);
    active <= 1'b1;
    tick <= 1'b1;
    repeat (40) @(posedge clk);
    active <= 1'b0;
    tick <= 1'b0;
    get(ACT_A, w);
    check(w, 64'h28);
    get(REF_A, v);
    check({63'h0, v == 64'h9 || v == 64'hA}, 64'h1);
    check(w / v, 64'(perf_state_pkg::REF_DIV));
    put(CTL_A, 64'h1234);
    get(CTL_A, v);
    check(v, {48'h0, perf_state_pkg::POINT_MAX});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    get(MISC_A, v);
    check(v, perf_state_pkg::MISC_RESET);
    check({48'h0, point}, {48'h0, perf_state_pkg::POINT_RESET});
    conclude();
  end
endmodule

// ===== rtl/feedback_counter_pair.sv
`timescale 1ns/1ps
module feedback_counter_pair (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ref_tick_i,
  input wire logic act_tick_i,
  input wire logic active_i,
  input wire logic wr_ref_i,
  input wire logic wr_act_i,
  input wire logic [63:0] wdata_i,
  output logic [63:0] ref_count_o,
  output logic [63:0] act_count_o
);
  logic [63:0] next_ref;
  logic [63:0] next_act;
  logic ref_wrap;
  logic act_wrap;

  always_comb begin
    next_ref = ref_count_o;
    next_act = act_count_o;
    ref_wrap = active_i && ref_tick_i && (&ref_count_o);
    act_wrap = active_i && act_tick_i && (&act_count_o);
    if (active_i && ref_tick_i) begin
      next_ref = ref_count_o + 64'h1; // [R9] [R11] [R22]
    end
    if (active_i && act_tick_i) begin
      next_act = act_count_o + 64'h1; // [R10] [R11] [R22]
    end
    // A wrap of either resets both so the ratio stays coherent
    if (ref_wrap || act_wrap) begin
      next_ref = 64'h0; // [R12]
      next_act = 64'h0; // [R12]
    end
    if (wr_ref_i) begin
      next_ref = wdata_i; // [R13]
    end
    if (wr_act_i) begin
      next_act = wdata_i; // [R13]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_count_o <= 64'h0;
      act_count_o <= 64'h0;
    end else begin
      ref_count_o <= next_ref;
      act_count_o <= next_act;
    end
  end
endmodule

// ===== rtl/perf_state_ctrl_feedback.sv
`timescale 1ns/1ps
// Function
// (R1) Identification feature word reports transition support at bit 7.
// (R2) Global enable is misc register bit 16, cleared on reset.
// (R3) Writing a 16-bit point to the control register starts a transition.
// (R4) A write during a transition is kept and followed afterwards.
// (R5) Control register reads return the last requested target.
// (R6) Status register reports the point in effect, updated as it moves.
// (R7) Codes above a device limit are not valid targets and are clamped.
// (R8) Identification leaf word reports feedback counters at bit 0.
// (R9) Reference counter at 0xE7 counts a fixed rate.
// (R10) Actual counter at 0xE8 counts delivered performance, throttles included.
// (R11) Counters advance only in the active power state.
// (R12) Wrap of either counter clears both together.
// (R13) Counters are 64 bits, each writable alone.
// (R14) Software records or zeroes counters at each window start.
// (R15) Software detects a wrap by a smaller new value.
// (R16) Software reads both counters back to back.
// (R17) Software uses only the ratio of the counts.
// (R18) Boost only when enabled, headroom present and criteria met.
// (R19) Control bit 32 disengages boost; clearing re-engages it.
// (R20) Disengage bit is private and not mirrored in status.
// (R21) Control writes are ignored while the global enable is clear.
// (R22) Reference counts divider ticks; actual counts delivered core clock ticks.
module perf_state_ctrl_feedback (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic [63:0] REG_WDATA_I,
  input wire logic ACTIVE_STATE_I,
  input wire logic CORE_CLK_TICK_I,
  input wire logic THERMAL_HEADROOM_I,
  input wire logic BOOST_CRITERIA_I,
  output logic [63:0] REG_RDATA_O,
  output logic [31:0] ID_FEATURE_ECX_O,
  output logic [31:0] ID_POWER_LEAF_ECX_O,
  output logic [15:0] OPERATING_POINT_O,
  output logic TRANSITION_BUSY_O,
  output logic BOOST_ENGAGED_O
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_STEP = 1'b1
  } trans_state_e;

  trans_state_e state;
  trans_state_e next_state;
  logic [63:0] misc_feature_enable;
  logic [63:0] next_misc;
  logic [15:0] target_point;
  logic [15:0] next_target;
  logic boost_disengage;
  logic next_disengage;
  logic [15:0] current_point;
  logic [15:0] next_current;
  logic [7:0] step_cnt;
  logic [7:0] next_step_cnt;
  logic [7:0] ref_div_cnt;
  logic [7:0] next_ref_div_cnt;
  logic [63:0] next_rdata;
  logic boost_on;
  logic next_boost;
  logic ref_tick;
  logic pstate_enabled;
  logic wr_ctl;
  logic wr_ref;
  logic wr_act;
  logic [63:0] ref_count;
  logic [63:0] act_count;

  // Out-of-range codes are clamped so a bad write still lands on a legal point
  function automatic logic [15:0] clamp_point(input logic [15:0] p);
    clamp_point = (p > perf_state_pkg::POINT_MAX) ? perf_state_pkg::POINT_MAX : p; // [R7]
  endfunction

  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] b);
    addr_hit = (a == b);
  endfunction

  assign pstate_enabled = misc_feature_enable[perf_state_pkg::PSTATE_ENABLE_BIT];
  assign wr_ctl = REG_WR_I && addr_hit(REG_ADDR_I, perf_state_pkg::ADDR_PERF_TARGET_CONTROL);
  assign wr_ref = REG_WR_I && addr_hit(REG_ADDR_I, perf_state_pkg::ADDR_REFERENCE_CYCLE_COUNT);
  assign wr_act = REG_WR_I && addr_hit(REG_ADDR_I, perf_state_pkg::ADDR_ACTUAL_CYCLE_COUNT);
  assign ref_tick = (ref_div_cnt == 8'(perf_state_pkg::REF_DIV - 1));

  // ----------------------------------------------------------------
  // Identification words
  // ----------------------------------------------------------------
  always_comb begin
    ID_FEATURE_ECX_O = 32'h0;
    ID_FEATURE_ECX_O[perf_state_pkg::ID_FEATURE_TRANSITION_BIT] = 1'b1; // [R1]
    ID_POWER_LEAF_ECX_O = 32'h0;
    ID_POWER_LEAF_ECX_O[perf_state_pkg::ID_FEEDBACK_COUNTERS_BIT] = 1'b1; // [R8]
  end

  // ----------------------------------------------------------------
  // Control registers and transition engine
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_misc = misc_feature_enable;
    next_target = target_point;
    next_disengage = boost_disengage;
    next_current = current_point;
    next_step_cnt = step_cnt;
    if (REG_WR_I && addr_hit(REG_ADDR_I, perf_state_pkg::ADDR_MISC_FEATURE_ENABLE)) begin
      next_misc = REG_WDATA_I; // [R2]
    end
    // Disabled feature leaves the whole control register untouched
    if (wr_ctl && pstate_enabled) begin // [R21]
      next_target = clamp_point(REG_WDATA_I[15:0]); // [R3] [R4]
      next_disengage = REG_WDATA_I[perf_state_pkg::BOOST_DISENGAGE_BIT]; // [R19]
    end
    // One code step per interval; a retarget mid-way just steers the next step
    case (state)
      ST_IDLE: begin
        if (current_point != target_point) begin
          next_state = ST_STEP; // [R3]
          next_step_cnt = 8'(perf_state_pkg::STEP_CYCLES - 1);
        end
      end
      ST_STEP: begin
        if (step_cnt != 8'h0) begin
          next_step_cnt = step_cnt - 8'h1;
        end else begin
          if (current_point < target_point) begin
            next_current = current_point + 16'h1; // [R6]
          end else if (current_point > target_point) begin
            next_current = current_point - 16'h1; // [R6]
          end
          next_state = ST_IDLE; // [R4]
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      state <= ST_IDLE;
      misc_feature_enable <= perf_state_pkg::MISC_RESET; // [R2]
      target_point <= perf_state_pkg::POINT_RESET;
      boost_disengage <= 1'b0;
      current_point <= perf_state_pkg::POINT_RESET;
      step_cnt <= 8'h0;
    end else begin
      state <= next_state;
      misc_feature_enable <= next_misc;
      target_point <= next_target;
      boost_disengage <= next_disengage;
      current_point <= next_current;
      step_cnt <= next_step_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Reference divider, boost, read data
  // ----------------------------------------------------------------
  always_comb begin
    // Free-running divider: phase fixed at reset, never retimed by register writes
    next_ref_div_cnt = ref_tick ? 8'h0 : ref_div_cnt + 8'h1; // [R22]
    // Boost is opportunistic: every condition must hold, never promised
    next_boost = pstate_enabled && !boost_disengage && THERMAL_HEADROOM_I && BOOST_CRITERIA_I; // [R18] [R19]
    // Held between reads so a slow reader still sees a steady word
    next_rdata = REG_RDATA_O;
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        perf_state_pkg::ADDR_MISC_FEATURE_ENABLE: next_rdata = misc_feature_enable;
        perf_state_pkg::ADDR_PERF_TARGET_CONTROL: begin
          next_rdata = 64'h0;
          next_rdata[15:0] = target_point; // [R5]
          next_rdata[perf_state_pkg::BOOST_DISENGAGE_BIT] = boost_disengage;
        end
        perf_state_pkg::ADDR_PERF_CURRENT_STATUS: next_rdata = {48'h0, current_point}; // [R6] [R20]
        perf_state_pkg::ADDR_REFERENCE_CYCLE_COUNT: next_rdata = ref_count;
        perf_state_pkg::ADDR_ACTUAL_CYCLE_COUNT: next_rdata = act_count;
        default: next_rdata = 64'h0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      ref_div_cnt <= 8'h0;
      boost_on <= 1'b0;
      REG_RDATA_O <= 64'h0;
    end else begin
      ref_div_cnt <= next_ref_div_cnt;
      boost_on <= next_boost;
      REG_RDATA_O <= next_rdata;
    end
  end

  // Status read and point pin share one register; a read returns the point the pin showed in the read cycle
  assign OPERATING_POINT_O = current_point;
  assign TRANSITION_BUSY_O = (state == ST_STEP);
  assign BOOST_ENGAGED_O = boost_on;

  // ----------------------------------------------------------------
  // Feedback counters
  // ----------------------------------------------------------------
  feedback_counter_pair i_feedback_counter_pair (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .ref_tick_i(ref_tick),
    .act_tick_i(CORE_CLK_TICK_I),
    .active_i(ACTIVE_STATE_I),
    .wr_ref_i(wr_ref),
    .wr_act_i(wr_act),
    .wdata_i(REG_WDATA_I),
    .ref_count_o(ref_count),
    .act_count_o(act_count)
  );
endmodule

// ===== rtl/perf_state_pkg.sv
package perf_state_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_MISC_FEATURE_ENABLE = 12'h1A0;
  localparam logic [11:0] ADDR_PERF_CURRENT_STATUS = 12'h198;
  localparam logic [11:0] ADDR_PERF_TARGET_CONTROL = 12'h199;
  localparam logic [11:0] ADDR_REFERENCE_CYCLE_COUNT = 12'h0E7;
  localparam logic [11:0] ADDR_ACTUAL_CYCLE_COUNT = 12'h0E8;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PSTATE_ENABLE_BIT = 16;
  localparam int BOOST_DISENGAGE_BIT = 32;
  localparam int POINT_WIDTH = 16;
  localparam int ID_FEATURE_TRANSITION_BIT = 7;
  localparam int ID_FEEDBACK_COUNTERS_BIT = 0;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [63:0] MISC_RESET = 64'h0000_0000_0000_0000;
  localparam logic [15:0] POINT_RESET = 16'h0000;
  localparam logic [15:0] POINT_MAX = 16'h00FF;
  localparam int STEP_TIME_NS = 1000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REF_DIV = 4;
endpackage
